// >>> logic/sehl_pkg.sv
// Package with constants and types for the secondary error header log.
package sehl_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [11:0] SEHL_OFS_WORD0 = 12'h13C;
  localparam logic [11:0] SEHL_OFS_WORD1 = 12'h140;
  localparam logic [11:0] SEHL_OFS_WORD2 = 12'h144;
  localparam logic [11:0] SEHL_OFS_WORD3 = 12'h148;
  localparam logic [31:0] SEHL_WORD_RESET = 32'h00000000;

  // ******************************************************************
  // Field layout of words 0 and 1 (log bits 63:0)
  // ******************************************************************
  localparam logic [19:0] SEHL_RSVD_ZERO = 20'h00000;
  localparam logic [3:0] SEHL_ATTR_ZERO = 4'h0;
  localparam logic [31:0] SEHL_UNUSED_ATTRIBUTE_FIELD = 32'h00000000;

  // ******************************************************************
  // Bus encodings
  // ******************************************************************
  localparam logic [3:0] SEHL_CMD_DUAL_ADDR = 4'hD;
  localparam logic [3:0] SEHL_CMD_ZERO = 4'h0;
  localparam logic [31:0] SEHL_ADDR_ZERO = 32'h00000000;

  // One logged transaction: both address phases and both command nibbles.
  typedef struct packed {
    logic [31:0] addr_hi;
    logic [31:0] addr_lo;
    logic [3:0] cmd_hi;
    logic [3:0] cmd_lo;
  } sehl_txn_s;

  localparam sehl_txn_s SEHL_TXN_RESET = '{
    addr_hi: 32'h00000000,
    addr_lo: 32'h00000000,
    cmd_hi: 4'h0,
    cmd_lo: 4'h0
  };

endpackage

// >>> logic/sehl_log.sv
// Secondary error header log: address-phase tracker and read-only words.
`timescale 1ns/1ns
module sehl_log
  import sehl_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Secondary bus pins, sampled as they appear on the bus.
  input wire logic sec_frame_n,
  input wire logic [31:0] sec_ad,
  input wire logic [3:0] sec_cbe_n,
  // Error event from the bridge's error detection logic.
  input wire logic err_detect,
  // Configuration space access.
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wr_data,
  output logic [31:0] cfg_rd_data,
  output logic cfg_rd_hit
);

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  // The bus pins follow their own timing, so no logic reads them raw.
  // Address and command stages run in step with the frame stages.
  logic frame_s1_r;
  logic frame_s2_r;
  logic frame_s3_r;
  logic [31:0] ad_s1_r;
  logic [31:0] ad_s2_r;
  logic [3:0] cbe_s1_r;
  logic [3:0] cbe_s2_r;

  // Two stages for every pin; the third frame stage only feeds edge
  // detection so that the first stage stays private to the second.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      frame_s1_r <= 1'b1;
      frame_s2_r <= 1'b1;
      frame_s3_r <= 1'b1;
      ad_s1_r <= SEHL_ADDR_ZERO;
      ad_s2_r <= SEHL_ADDR_ZERO;
      cbe_s1_r <= SEHL_CMD_ZERO;
      cbe_s2_r <= SEHL_CMD_ZERO;
    end else begin
      frame_s1_r <= sec_frame_n;
      frame_s2_r <= frame_s1_r;
      frame_s3_r <= frame_s2_r;
      ad_s1_r <= sec_ad;
      ad_s2_r <= ad_s1_r;
      cbe_s1_r <= sec_cbe_n;
      cbe_s2_r <= cbe_s1_r;
    end
  end

  // ******************************************************************
  // Address phase tracking
  // ******************************************************************
  // Phase strobes and the transaction being assembled.
  wire first_phase;
  wire second_phase;
  wire is_dual;
  logic dual_pend_r;
  sehl_txn_s cur_r;
  sehl_txn_s cur_nxt;

  // A falling frame marks the first address phase; a dual-address
  // command there means the very next cycle is the second phase.
  assign first_phase = frame_s3_r & ~frame_s2_r;
  assign second_phase = dual_pend_r;
  assign is_dual = (cbe_s2_r == SEHL_CMD_DUAL_ADDR);

  // Build the transaction being seen on the bus right now.
  always_comb begin
    cur_nxt = cur_r;
    if (first_phase) begin
      cur_nxt.addr_lo = ad_s2_r;
      cur_nxt.cmd_lo = cbe_s2_r;
      cur_nxt.addr_hi = SEHL_ADDR_ZERO;
      cur_nxt.cmd_hi = SEHL_CMD_ZERO;
    end else if (second_phase) begin
      cur_nxt.addr_hi = ad_s2_r;
      cur_nxt.cmd_hi = cbe_s2_r;
    end
  end

  // Tracker registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dual_pend_r <= 1'b0;
      cur_r <= SEHL_TXN_RESET;
    end else begin
      dual_pend_r <= first_phase & is_dual;
      cur_r <= cur_nxt;
    end
  end

  // ******************************************************************
  // Error log
  // ******************************************************************
  // The log itself; only reset and an error event ever write it.
  sehl_txn_s log_r;

  // The log takes the transaction as it stood before this cycle, so an
  // error flagged during a new address phase still blames the old one.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      log_r <= SEHL_TXN_RESET;
    end else if (err_detect) begin
      log_r <= cur_r;
    end
  end

  // ******************************************************************
  // Configuration read path
  // ******************************************************************
  // Word images, hit strobes and the selected read word.
  wire [31:0] word0;
  wire [31:0] word1;
  wire [31:0] word2;
  wire [31:0] word3;
  wire hit0;
  wire hit1;
  wire hit2;
  wire hit3;
  wire any_hit;
  wire [31:0] rd_sel;

  // Word images; reserved and attribute bits are constant zero.
  assign word0 = SEHL_UNUSED_ATTRIBUTE_FIELD;
  assign word1 = {SEHL_RSVD_ZERO, log_r.cmd_hi, log_r.cmd_lo,
                  SEHL_ATTR_ZERO};
  assign word2 = log_r.addr_lo;
  assign word3 = log_r.addr_hi;

  // Address decode onto four consecutive words.
  assign hit0 = (cfg_addr == SEHL_OFS_WORD0);
  assign hit1 = (cfg_addr == SEHL_OFS_WORD1);
  assign hit2 = (cfg_addr == SEHL_OFS_WORD2);
  assign hit3 = (cfg_addr == SEHL_OFS_WORD3);
  assign any_hit = hit0 | hit1 | hit2 | hit3;
  assign rd_sel = ({32{hit0}} & word0) | ({32{hit1}} & word1) |
                  ({32{hit2}} & word2) | ({32{hit3}} & word3);

  // Read data is registered; writes are deliberately never decoded, so
  // cfg_wr and cfg_wr_data have no effect on the log.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cfg_rd_data <= SEHL_WORD_RESET;
      cfg_rd_hit <= 1'b0;
    end else begin
      cfg_rd_data <= cfg_rd ? rd_sel : SEHL_WORD_RESET;
      cfg_rd_hit <= cfg_rd & any_hit;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  // All checks share the core clock and rest while reset is held; the
  // reset check overrides that default so that it can see reset itself.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // An error copies the transaction held before that edge.
  chk_log_overwrite: assert property (
    err_detect |=> log_r == $past(cur_r))
    else $error("Log did not take the current transaction.");

  // The top word returns the second address phase as logged.
  chk_word_order: assert property (
    cfg_rd && hit3 |=> cfg_rd_hit && cfg_rd_data == $past(log_r.addr_hi))
    else $error("Top word does not return log bits 127:96.");

  // Once taken, the first phase stays put in the tracker.
  chk_first_phase: assert property (
    first_phase ##1 (!err_detect && !second_phase) [*2]
    |-> log_r.addr_lo == $past(log_r.addr_lo) &&
        cur_r.addr_lo == $past(ad_s2_r, 2))
    else $error("First address phase not held as low address.");

  // A single address cycle leaves the upper address zero.
  chk_single_zero: assert property (
    first_phase && !is_dual ##1 err_detect |=> log_r.addr_hi == 32'h0)
    else $error("Single address cycle left upper address nonzero.");

  // The reserved field never reads back anything but zero.
  chk_rsvd_zero: assert property (
    cfg_rd && hit1 |=> cfg_rd_data[31:12] == 20'h0)
    else $error("Reserved bits read nonzero.");

  // A dual cycle logs the second phase's command and address.
  chk_dual_cmd: assert property (
    first_phase && is_dual ##1 !first_phase ##1 err_detect
    |=> log_r.cmd_hi == $past(cbe_s2_r, 2) &&
        log_r.addr_hi == $past(ad_s2_r, 2))
    else $error("Second phase command or address not logged.");

  // The first phase's command always lands in the low nibble.
  chk_low_cmd: assert property (
    first_phase ##1 err_detect |=> log_r.cmd_lo == $past(cbe_s2_r, 2))
    else $error("First phase command not logged.");

  // The attribute field and the whole lowest word read as zero.
  chk_attr_zero: assert property (
    cfg_rd && (hit0 || hit1) |=> cfg_rd_data[3:0] == 4'h0 &&
      (!$past(hit0) || cfg_rd_data == 32'h0))
    else $error("Attribute bits read nonzero.");

  // Without an error nothing moves the log, reads included.
  chk_read_quiet: assert property (
    !err_detect |=> $stable(log_r))
    else $error("Log changed without an error event.");

  // Reset clears the log and the read port. The default disable would
  // switch this check off exactly when it matters, so it is overridden.
  chk_reset_clear: assert property (@(posedge ref_clk)
    disable iff (1'b0)
    !nrst |=> log_r == SEHL_TXN_RESET && cfg_rd_data == SEHL_WORD_RESET &&
      !cfg_rd_hit)
    else $error("Log not cleared by reset.");

  // The third word returns the first address phase as logged.
  chk_low_word: assert property (
    cfg_rd && hit2 |=> cfg_rd_hit && cfg_rd_data == $past(log_r.addr_lo))
    else $error("Third word does not return log bits 95:64.");

  // The second word packs both commands between constant zero fields.
  chk_cmd_word: assert property (
    cfg_rd && hit1 |=> cfg_rd_hit &&
      cfg_rd_data == {SEHL_RSVD_ZERO, $past(log_r.cmd_hi),
                      $past(log_r.cmd_lo), SEHL_ATTR_ZERO})
    else $error("Second word does not return log bits 63:32.");

  // The lowest word is answered as a hit, and always with zero.
  chk_zero_word: assert property (
    cfg_rd && hit0 |=> cfg_rd_hit && cfg_rd_data == SEHL_WORD_RESET)
    else $error("Lowest word read nonzero.");

  // An unmapped offset answers with neither a hit nor data.
  chk_unmapped_read: assert property (
    cfg_rd && !any_hit |=> !cfg_rd_hit && cfg_rd_data == SEHL_WORD_RESET)
    else $error("Unmapped read returned a hit or data.");

  // Between reads the port rests at zero, so stale data never shows.
  chk_idle_zero: assert property (
    !cfg_rd |=> !cfg_rd_hit && cfg_rd_data == SEHL_WORD_RESET)
    else $error("Read port not at rest without a read.");

  // A write, wherever it points, leaves the log untouched.
  chk_write_ignored: assert property (
    cfg_wr && !err_detect |=> $stable(log_r))
    else $error("Write changed the log.");

  // Every new first phase starts with the upper half cleared.
  chk_new_phase: assert property (
    first_phase |=> cur_r.addr_hi == SEHL_ADDR_ZERO &&
      cur_r.cmd_hi == SEHL_CMD_ZERO && cur_r.addr_lo == $past(ad_s2_r))
    else $error("New address phase kept the old upper half.");

  // A dual command is always followed by the second phase.
  chk_dual_follow: assert property (
    first_phase && is_dual |=> second_phase)
    else $error("Dual command not followed by a second phase.");

  // The second phase lasts one cycle only.
  chk_pend_clear: assert property (
    second_phase |=> !second_phase)
    else $error("Second phase held for more than one cycle.");

  // A single cycle logs a zero upper command as well.
  chk_single_cmd: assert property (
    first_phase && !is_dual ##1 err_detect |=> log_r.cmd_hi == SEHL_CMD_ZERO)
    else $error("Single address cycle left upper command nonzero.");

  // Every mapped offset is answered with a hit.
  chk_hit_mapped: assert property (
    cfg_rd && any_hit |=> cfg_rd_hit)
    else $error("Mapped read not answered with a hit.");

  // A first phase is a single-cycle strobe from the frame edge.
  chk_phase_spacing: assert property (
    first_phase |=> !first_phase)
    else $error("First phase strobe lasted more than one cycle.");

  // A hit is only ever the answer to a read.
  chk_rd_hit_only: assert property (
    cfg_rd_hit |-> $past(cfg_rd))
    else $error("Read hit raised without a read.");

  // ******************************************************************
  // Cover points
  // ******************************************************************
  // An error right behind a dual address cycle.
  cov_dual_logged: cover property (
    first_phase && is_dual ##2 err_detect);
  // An error right behind a single address cycle.
  cov_single_logged: cover property (
    first_phase && !is_dual ##1 err_detect);
  // A read of the low address word that is answered.
  cov_read_hit: cover property (cfg_rd && hit2 ##1 cfg_rd_hit);
  // A read of an offset outside the log.
  cov_unmapped: cover property (cfg_rd && !any_hit);
  // A write that must leave the log alone.
  cov_write_seen: cover property (cfg_wr && !err_detect);

endmodule

// >>> tb/sehl_pci_init.sv
// Behavioural secondary-bus initiator that issues address phases.
`timescale 1ns/1ns
module sehl_pci_init (
  // Clock.
  input wire logic ref_clk,
  // Secondary bus pins.
  output logic sec_frame_n,
  output logic [31:0] sec_ad,
  output logic [3:0] sec_cbe_n
);
  logic busy = 1'b0;
  // Lines start idle with the frame released.
  initial begin
    sec_frame_n = 1'b1;
    sec_ad = 32'h00000000;
    sec_cbe_n = 4'hF;
  end
  // Released address lines keep changing, so a stale address never looks valid.
  always @(posedge ref_clk) begin
    #1;
    if (!busy) sec_ad = ~sec_ad;
  end
  // One transaction: a claim cycle, address phase(s), one data phase,
  // then release; claiming first keeps the idle toggling off the lines.
  task automatic run(input logic dual, input logic [31:0] a0,
                     input logic [3:0] c0, input logic [31:0] a1,
                     input logic [3:0] c1);
    busy = 1'b1;
    @(posedge ref_clk);
    #1;
    sec_frame_n = 1'b0;
    sec_ad = a0;
    sec_cbe_n = c0;
    @(posedge ref_clk);
    #1;
    if (dual) begin
      sec_ad = a1;
      sec_cbe_n = c1;
      @(posedge ref_clk);
      #1;
    end
    sec_ad = ~sec_ad;
    sec_cbe_n = ~sec_cbe_n;
    sec_frame_n = 1'b1;
    @(posedge ref_clk);
    #1;
    sec_cbe_n = 4'hF;
    busy = 1'b0;
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the secondary error header log.
`timescale 1ns/1ns
module tb;
  import sehl_pkg::*;
  logic ref_clk, nrst, err_detect, cfg_rd, cfg_wr, cfg_rd_hit, dual;
  logic sec_frame_n;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wr_data, cfg_rd_data, sec_ad, seed, a0, a1, w1, w2, w3;
  logic [3:0] sec_cbe_n, c0, c1;
  logic [32:0] exp_q[$];
  int err_total = 0;
  int check_count = 0;
  sehl_log dut (.ref_clk(ref_clk), .nrst(nrst), .sec_frame_n(sec_frame_n),
    .sec_ad(sec_ad), .sec_cbe_n(sec_cbe_n), .err_detect(err_detect),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
    .cfg_rd_hit(cfg_rd_hit));
  sehl_pci_init u_bus (.ref_clk(ref_clk), .sec_frame_n(sec_frame_n),
    .sec_ad(sec_ad), .sec_cbe_n(sec_cbe_n));
  // Free-running core clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Xorshift source, reproducible from its fixed start.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Inputs always move 1 ns after the rising edge.
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  // Compare one read answer with its note.
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value read hit_data expected %h seen %h", exp, seen);
    end
  endtask
  // Issue a read and note its answer; the caller drops the strobe.
  task rd(input logic [11:0] a, input logic h, input logic [31:0] d);
    cfg_rd = 1'b1;
    cfg_addr = a;
    exp_q.push_back({h, d});
    tick;
  endtask
  // Back-to-back reads of all words plus one unmapped offset.
  task rd_all;
    rd(SEHL_OFS_WORD0, 1'b1, SEHL_WORD_RESET);
    rd(SEHL_OFS_WORD1, 1'b1, w1);
    rd(SEHL_OFS_WORD2, 1'b1, w2);
    rd(SEHL_OFS_WORD3, 1'b1, w3);
    rd(12'h14C, 1'b0, 32'h00000000);
    cfg_rd = 1'b0;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The answer lands on the same edge that takes the strobe and is checked 2 ns later.
  always @(posedge ref_clk) begin : watch
    logic p;
    p = cfg_rd;
    #2;
    if (p) chk({cfg_rd_hit, cfg_rd_data}, exp_q.pop_front());
  end
  // A hang is cut short well past the expected run length.
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
  // **********************************************************
  // Stimulus
  // **********************************************************
  // Alternating single and dual cycles show that zeros replace old bits.
  initial begin
    seed = 32'h0000001C;
    {nrst, err_detect, cfg_rd, cfg_wr} = 4'h0;
    cfg_addr = 12'h000;
    cfg_wr_data = 32'h00000000;
    {w1, w2, w3} = '0;
    repeat (8) tick;
    nrst = 1'b1;
    tick;
    rd_all();
    for (int i = 0; i < 8; i++) begin
      a0 = xs();
      a1 = xs();
      dual = i[0];
      c1 = a1[3:0];
      c0 = (a0[3:0] == SEHL_CMD_DUAL_ADDR) ? 4'h6 : a0[3:0];
      if (dual) c0 = SEHL_CMD_DUAL_ADDR;
      u_bus.run(dual, a0, c0, a1, c1);
      // Passes 0, 1, 4 and 5 raise the error right behind the address
      // phases, the others later; a read of the old log runs alongside.
      tick;
      if (i[1]) repeat (3) tick;
      err_detect = 1'b1;
      rd(SEHL_OFS_WORD2, 1'b1, w2);
      err_detect = 1'b0;
      cfg_rd = 1'b0;
      w1 = {SEHL_RSVD_ZERO, dual ? c1 : 4'h0, c0, 4'h0};
      w2 = a0;
      w3 = dual ? a1 : SEHL_ADDR_ZERO;
      cfg_wr = 1'b1;
      cfg_addr = SEHL_OFS_WORD0 + 12'(4 * (i % 4));
      cfg_wr_data = xs();
      tick;
      cfg_wr = 1'b0;
      rd_all();
    end
    nrst = 1'b0;
    repeat (3) tick;
    nrst = 1'b1;
    tick;
    {w1, w2, w3} = '0;
    rd_all();
    repeat (3) tick;
    test_done();
  end
endmodule
